//--- verilog/ccr_pkg.sv
// Shared constants and types for the charger configuration register bank
package ccr_pkg;

  // Bus slave address of the bank
  localparam logic [3:0] GROUP_ID      = 4'h9;   // 1001b
  localparam logic [2:0] DEVICE_ID     = 3'h0;   // 000b
  localparam logic [6:0] SLAVE_ADDR    = {GROUP_ID, DEVICE_ID};

  // Register subaddresses
  localparam logic [7:0] OFS_TERM_CFG  = 8'h02;
  localparam logic [7:0] OFS_CUR_CFG   = 8'h04;
  localparam logic [7:0] OFS_UNLOCK    = 8'h11;
  localparam logic [7:0] OFS_NVM_CTRL  = 8'h12;

  // Field positions
  localparam int         TERM_LSB      = 3;
  localparam int         TERM_W        = 3;
  localparam int         CUR_LSB       = 4;
  localparam int         CUR_W         = 4;
  localparam int         UNLOCK_BIT    = 0;
  localparam int         BURN_BIT      = 0;

  // Reset values
  localparam logic [7:0] RST_UNLOCK    = 8'h00;
  localparam logic [7:0] RST_NVM_CTRL  = 8'h00;
  localparam logic [7:0] RST_CFG       = 8'h00;
  localparam logic [7:0] READ_NONE     = 8'h00;

  // Termination code reserved for factory use
  localparam logic [2:0] TERM_FACTORY  = 3'h7;

  // Charge current encoding, milliamps
  localparam logic [10:0] CUR_MIN_MA   = 11'h032; // 50 mA
  localparam logic [10:0] CUR_STEP_MA  = 11'h064; // 100 mA

  // Supply hold time the host must keep during a burn, milliseconds
  localparam int         BURN_HOLD_MS  = 200;

  // Register access request from the serial slave front end
  typedef struct packed {
    logic       valid;     // One-cycle request strobe
    logic       write;     // 1 write, 0 read
    logic [6:0] dev_addr;  // Slave address of the transfer
    logic [7:0] sub_addr;  // Register subaddress (first data byte)
    logic [7:0] wdata;     // Write data
  } ccr_req_t;

  // Nonvolatile image of the two configuration registers
  typedef struct packed {
    logic [7:0] term_cfg;
    logic [7:0] cur_cfg;
  } ccr_nvm_t;

endpackage

//--- verilog/ccr_top.sv
// Configuration register bank of the supercapacitor charger
//
// Contract
// - Termination select 000..110 map 2.48..2.74 V; 111 is factory only.
// - Current select 0000 gives 50 mA; 0001..1111 give 100..1500 mA.
// - Unlock bit 0 of 0x11 resets to 0; 0 blocks config access.
// - Burn control bit 0 of 0x12 resets 0; upper bits read zero.
// - Writing burn bit 1 programs nonvolatile memory with registers 2 and 4.
// - Burn bit at 0 never starts nonvolatile programming.
// - Config and burn registers need unlock; unlock register always open, resets 0x00.
// - Bank answers slave address 0x48; first data byte is subaddress.
`timescale 1ns/100ps

module ccr_top (
  input  wire logic              CLK_SYS,       // System clock, 100 MHz
  input  wire logic              NRST,          // Asynchronous reset, active low
  input  wire ccr_pkg::ccr_req_t REQ,           // Register access request
  input  wire ccr_pkg::ccr_nvm_t NVM_IMAGE,     // Stored configuration image
  input  wire logic              NVM_IMAGE_OK,  // Stored image valid
  output logic [7:0]             RSP_RDATA,     // Read data
  output logic                   RSP_VALID,     // Read data strobe
  output logic [2:0]             TERM_SEL,      // Termination voltage select
  output logic [11:0]            TERM_MV,       // Termination voltage, millivolts
  output logic                   TERM_FACTORY,  // Factory-only code selected
  output logic [3:0]             CUR_SEL,       // Charge current limit select
  output logic [10:0]            CUR_MA,        // Charge current limit, milliamps
  output logic                   NVM_BURN,      // Burn request pulse
  output ccr_pkg::ccr_nvm_t      NVM_BURN_DATA  // Image to burn
);

  // Stored state
  logic                rst_s1_q;
  logic                rst_n_q;
  logic                loaded_q;
  logic [2:0]          term_q;
  logic [3:0]          cur_q;
  logic                unlock_q;
  logic                burn_ctrl_q;
  // Decodes and next values
  logic                hit;
  logic                open_cfg;
  logic                wr_unlock;
  logic                wr_term;
  logic                wr_cur;
  logic                wr_ctrl;
  logic                rd_take;
  logic [7:0]          rdata_d;
  logic [11:0]         term_mv_d;
  logic [10:0]         cur_ma_d;

  // Reset release through two flops
  // Assertion acts at once; release waits for two clean edges
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Address match and unlock gate
  // Other slave addresses are ignored entirely
  assign hit      = REQ.valid && (REQ.dev_addr == ccr_pkg::SLAVE_ADDR);
  assign open_cfg = unlock_q;

  // Write and read decodes; config writes need the unlock bit
  assign wr_unlock = hit && REQ.write && (REQ.sub_addr == ccr_pkg::OFS_UNLOCK);
  assign wr_term   = hit && REQ.write && open_cfg && (REQ.sub_addr == ccr_pkg::OFS_TERM_CFG);
  assign wr_cur    = hit && REQ.write && open_cfg && (REQ.sub_addr == ccr_pkg::OFS_CUR_CFG);
  assign wr_ctrl   = hit && REQ.write && open_cfg && (REQ.sub_addr == ccr_pkg::OFS_NVM_CTRL);
  assign rd_take   = hit && !REQ.write;

  // Unlock register, always reachable
  // Only bit 0 is kept; the upper bits read back zero
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      unlock_q <= ccr_pkg::RST_UNLOCK[ccr_pkg::UNLOCK_BIT];
    end else if (wr_unlock) begin
      unlock_q <= REQ.wdata[ccr_pkg::UNLOCK_BIT];
    end
  end

  // Configuration fields, loaded once from the stored image after reset
  // A write landing on the load edge is lost; hosts wait past it
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loaded_q <= 1'b0;
      term_q   <= ccr_pkg::RST_CFG[ccr_pkg::TERM_LSB +: ccr_pkg::TERM_W];
      cur_q    <= ccr_pkg::RST_CFG[ccr_pkg::CUR_LSB +: ccr_pkg::CUR_W];
    end else if (!loaded_q) begin
      // First edge after release takes the stored image
      loaded_q <= 1'b1;
      if (NVM_IMAGE_OK) begin
        term_q <= NVM_IMAGE.term_cfg[ccr_pkg::TERM_LSB +: ccr_pkg::TERM_W];
        cur_q  <= NVM_IMAGE.cur_cfg[ccr_pkg::CUR_LSB +: ccr_pkg::CUR_W];
      end
    end else begin
      // Only the field bits are stored; the rest are dropped
      if (wr_term) begin
        term_q <= REQ.wdata[ccr_pkg::TERM_LSB +: ccr_pkg::TERM_W];
      end
      if (wr_cur) begin
        cur_q <= REQ.wdata[ccr_pkg::CUR_LSB +: ccr_pkg::CUR_W];
      end
    end
  end

  // Burn control bit
  // Holds as written; only a fresh write of 1 asks for another burn
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      burn_ctrl_q <= ccr_pkg::RST_NVM_CTRL[ccr_pkg::BURN_BIT];
    end else if (wr_ctrl) begin
      burn_ctrl_q <= REQ.wdata[ccr_pkg::BURN_BIT];
    end
  end

  // Burn request: one pulse per write of 1, carrying the live image
  // Image comes from the fields before this edge, never half-updated
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      NVM_BURN      <= 1'b0;
      NVM_BURN_DATA <= '0;
    end else begin
      NVM_BURN <= wr_ctrl && REQ.wdata[ccr_pkg::BURN_BIT];
      if (wr_ctrl) begin
        NVM_BURN_DATA.term_cfg <= 8'(term_q) << ccr_pkg::TERM_LSB;
        NVM_BURN_DATA.cur_cfg  <= 8'(cur_q) << ccr_pkg::CUR_LSB;
      end
    end
  end

  // Read data mux; locked and unmapped reads give zero
  // Address decode only; the strobe is qualified at the answer flops
  always_comb begin
    rdata_d = ccr_pkg::READ_NONE;
    case (REQ.sub_addr)
      ccr_pkg::OFS_UNLOCK: begin
        rdata_d[ccr_pkg::UNLOCK_BIT] = unlock_q;
      end
      ccr_pkg::OFS_TERM_CFG: begin
        if (open_cfg) begin
          rdata_d[ccr_pkg::TERM_LSB +: ccr_pkg::TERM_W] = term_q;
        end
      end
      ccr_pkg::OFS_CUR_CFG: begin
        if (open_cfg) begin
          rdata_d[ccr_pkg::CUR_LSB +: ccr_pkg::CUR_W] = cur_q;
        end
      end
      ccr_pkg::OFS_NVM_CTRL: begin
        if (open_cfg) begin
          rdata_d[ccr_pkg::BURN_BIT] = burn_ctrl_q;
        end
      end
      default: begin
        rdata_d = ccr_pkg::READ_NONE;
      end
    endcase
  end

  // Read answer, one cycle after the request
  // Data holds between answers for a slow front end
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= ccr_pkg::READ_NONE;
    end else begin
      RSP_VALID <= rd_take;
      if (rd_take) begin
        RSP_RDATA <= rdata_d;
      end
    end
  end

  // Termination decode, millivolts
  // Factory code has no charging target here; shown as zero
  always_comb begin
    case (term_q)
      3'h0:    term_mv_d = 12'h9b0;  // 2480
      3'h1:    term_mv_d = 12'h9ec;  // 2540
      3'h2:    term_mv_d = 12'ha28;  // 2600
      3'h3:    term_mv_d = 12'ha64;  // 2660
      3'h4:    term_mv_d = 12'ha78;  // 2680
      3'h5:    term_mv_d = 12'haa0;  // 2720
      3'h6:    term_mv_d = 12'hab4;  // 2740
      default: term_mv_d = 12'h000;  // Factory use
    endcase
  end

  // Current decode, milliamps
  // Lowest code is a fixed trickle level, not a step multiple
  always_comb begin
    if (cur_q == 4'h0) begin
      cur_ma_d = ccr_pkg::CUR_MIN_MA;
    end else begin
      cur_ma_d = 11'(cur_q * ccr_pkg::CUR_STEP_MA);
    end
  end

  // Registered charger controls
  // One flop between field and pin keeps the outputs glitch free
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      TERM_SEL     <= 3'h0;
      TERM_MV      <= 12'h000;
      TERM_FACTORY <= 1'b0;
      CUR_SEL      <= 4'h0;
      CUR_MA       <= 11'h000;
    end else begin
      TERM_SEL     <= term_q;
      TERM_MV      <= term_mv_d;
      TERM_FACTORY <= (term_q == ccr_pkg::TERM_FACTORY);
      CUR_SEL      <= cur_q;
      CUR_MA       <= cur_ma_d;
    end
  end

endmodule

//--- tb/ccr_nvm_model.sv
// Behavioural nonvolatile store behind the burn request
`timescale 1ns/100ps
module ccr_nvm_model (
  input  wire logic              clk,    // System clock
  input  wire logic              burn,   // Burn request pulse
  input  wire ccr_pkg::ccr_nvm_t data,   // Image to burn
  output ccr_pkg::ccr_nvm_t      image,  // Stored image
  output logic                   ok,     // Stored image valid
  output int                     burns   // Burns taken
);
  // Stored image at power up: 2.60 V and 300 mA
  initial begin
    image = 16'h1030;
    ok = 1'b1;
    burns = 0;
  end
  // Burn taken at once; supply and enable never drop, so the hold is kept
  always @(posedge clk) begin
    if (burn === 1'b1) begin
      image <= data;
      burns <= burns + 1;
    end
  end
endmodule

//--- tb/ccr_top_chk.sv
// Port assertions for the configuration register bank
`timescale 1ns/100ps
module ccr_top_chk (
  input wire logic              CLK_SYS,       // Clock
  input wire logic              NRST,          // Reset, active low
  input wire ccr_pkg::ccr_req_t REQ,           // Request
  input wire logic [7:0]        RSP_RDATA,     // Read data
  input wire logic              RSP_VALID,     // Read strobe
  input wire logic [2:0]        TERM_SEL,      // Termination code
  input wire logic [11:0]       TERM_MV,       // Termination mV
  input wire logic              TERM_FACTORY,  // Factory code
  input wire logic [3:0]        CUR_SEL,       // Current code
  input wire logic [10:0]       CUR_MA,        // Current mA
  input wire logic              NVM_BURN,      // Burn pulse
  input wire ccr_pkg::ccr_nvm_t NVM_BURN_DATA  // Burn image
);
  localparam logic [11:0] MV [8] = '{12'h9b0, 12'h9ec, 12'ha28, 12'ha64,
                                     12'ha78, 12'haa0, 12'hab4, 12'h000};
  logic       take;
  logic       burn_req;
  logic [2:0] live_q;
  default clocking @(posedge CLK_SYS); endclocking
  // Quiet until the bank's own reset release has reached the outputs
  default disable iff (live_q != 3'h4);
  // Edges since the reset pin rose
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      live_q <= 3'h0;
    end else if (live_q != 3'h4) begin
      live_q <= live_q + 3'h1;
    end
  end
  // Request aimed at this bank, and a burn asked for
  assign take = REQ.valid && REQ.dev_addr == ccr_pkg::SLAVE_ADDR;
  assign burn_req = take && REQ.write && REQ.sub_addr == ccr_pkg::OFS_NVM_CTRL
                    && REQ.wdata[ccr_pkg::BURN_BIT];
  a_read_answer: assert property (take && !REQ.write |=> RSP_VALID)
    else $error("Read not answered");
  a_no_stray: assert property (!(take && !REQ.write) |=> !RSP_VALID)
    else $error("Answer without read");
  a_rdata_hold: assert property ($changed(RSP_RDATA) |-> RSP_VALID)
    else $error("Read data moved");
  a_ctrl_upper: assert property (take && !REQ.write
    && REQ.sub_addr inside {8'h11, 8'h12} |=> RSP_RDATA[7:1] == 7'h00)
    else $error("Upper control bits set");
  a_burn_cause: assert property (NVM_BURN |-> $past(burn_req))
    else $error("Burn without request");
  a_burn_image: assert property (NVM_BURN |->
    NVM_BURN_DATA == {2'h0, TERM_SEL, 3'h0, CUR_SEL, 4'h0}) else $error("Wrong image");
  a_term_map: assert property (TERM_MV == MV[TERM_SEL])
    else $error("Termination decode wrong");
  a_factory_flag: assert property (TERM_FACTORY == (TERM_SEL == 3'h7))
    else $error("Factory flag wrong");
  a_cur_map: assert property (CUR_MA == (CUR_SEL == 4'h0 ? 11'h032 : CUR_SEL * 11'h064))
    else $error("Current decode wrong");
endmodule
bind ccr_top ccr_top_chk u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ(REQ),
  .RSP_RDATA(RSP_RDATA), .RSP_VALID(RSP_VALID), .TERM_SEL(TERM_SEL), .TERM_MV(TERM_MV),
  .TERM_FACTORY(TERM_FACTORY), .CUR_SEL(CUR_SEL), .CUR_MA(CUR_MA), .NVM_BURN(NVM_BURN),
  .NVM_BURN_DATA(NVM_BURN_DATA));

//--- tb/ccr_top_test.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module ccr_top_test;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  ccr_pkg::ccr_req_t req = '0;
  ccr_pkg::ccr_nvm_t image, burn_data;
  logic              image_ok, rsp_valid, burn, factory;
  logic [7:0]        rdata;
  logic [2:0]        term_sel;
  logic [11:0]       term_mv;
  logic [3:0]        cur_sel;
  logic [10:0]       cur_ma;
  int                burns, miscompares = 0, num_checks = 0;
  always #5 clk = ~clk;
  ccr_top DUT (.CLK_SYS(clk), .NRST(nrst), .REQ(req), .NVM_IMAGE(image),
    .NVM_IMAGE_OK(image_ok), .RSP_RDATA(rdata), .RSP_VALID(rsp_valid), .TERM_SEL(term_sel),
    .TERM_MV(term_mv), .TERM_FACTORY(factory), .CUR_SEL(cur_sel), .CUR_MA(cur_ma),
    .NVM_BURN(burn), .NVM_BURN_DATA(burn_data));
  ccr_nvm_model u_nvm (.clk(clk), .burn(burn), .data(burn_data), .image(image),
    .ok(image_ok), .burns(burns));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request, held for one taking edge
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] s, d);
    @(posedge clk);
    req <= '{1'b1, w, a, s, d};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    xfer(1'b1, ccr_pkg::SLAVE_ADDR, s, d);
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] exp);
    xfer(1'b0, ccr_pkg::SLAVE_ADDR, s, 8'h00);
    chk({7'h00, rsp_valid, rdata}, {8'h01, exp});
  endtask
  // Locked bank: stored image in use, config and burn closed
  task automatic t_locked();
    rd(8'h11, 8'h00);
    wr(8'h02, 8'h30);
    wr(8'h12, 8'h01);
    rd(8'h02, 8'h00);
    rd(8'h12, 8'h00);
    chk({term_sel, cur_sel}, 16'h0023);
    chk(burns, 16'h0000);
    $display("Locked access test done");
  endtask
  // Every termination and current code, unused bits set
  task automatic t_codes();
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'h02, 8'(c << 3) | 8'hc7);
      rd(8'h02, 8'(c << 3));
      chk({factory, term_sel}, {c == 7, 3'(c)});
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h04, 8'(c << 4) | 8'h0f);
      rd(8'h04, 8'(c << 4));
      chk(cur_ma, c == 0 ? 16'h0032 : 16'(c * 16'h0064));
    end
    $display("Code table test done");
  endtask
  // Burn, no burn on zero, foreign address and hole ignored
  task automatic t_burn();
    wr(8'h02, 8'h28);
    wr(8'h04, 8'ha0);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h01);
    chk(image, 16'h28a0);
    wr(8'h12, 8'h00);
    xfer(1'b1, 7'h49, 8'h12, 8'h01);
    rd(8'h12, 8'h00);
    rd(8'h03, 8'h00);
    chk(burns, 16'h0001);
    xfer(1'b0, 7'h49, 8'h11, 8'h00);
    chk(rsp_valid, 16'h0000);
    $display("Burn test done");
  endtask
  // Mid-run reset, released as at start
  task automatic reset_bank();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Reset reloads the burned image, or zero codes when the image is bad
  task automatic t_reset();
    wr(8'h02, 8'h00);
    reset_bank();
    chk({term_sel, cur_sel}, 16'h005a);
    rd(8'h11, 8'h00);
    u_nvm.ok <= 1'b0;
    reset_bank();
    chk(term_mv, 16'h09b0);
    chk(cur_ma, 16'h0032);
    $display("Reset reload test done");
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    t_locked();
    t_codes();
    t_burn();
    t_reset();
    stop_test();
  end
  // Watchdog, far beyond the roughly 160 cycles needed
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
